//--- sofc_format_config.sv
// Output data format configuration for the sensor's LVDS readout lanes.
// Assumes host access over the serial control port and pixel words arriving on link_clk.
//
// Overview of operation
// RQ1: Channel-count code selects lanes per side
// RQ2: Lanes 0-31 bottom, 32-63 top
// RQ3: One-side flag keeps top lanes unread
// RQ4: Host writes 65535 offset in one-side mode
// RQ5: Host avoids subsampling with one-side readout
// RQ6: Training word sent when no valid data
// RQ7: Training word from 12-bit field, reset 85
// RQ8: Depth code 0/1/2 gives 12/10/8 bits
// RQ9: Host sets matching ramp range code
// RQ10: Host sets ramp multiplier per depth
// RQ11: Secondary multiplier only with primary three
// RQ12: Host slows link clock only at start-up
// RQ13: Bottom lanes enabled bit by bit
// RQ14: Top lanes enabled bit by bit
// RQ15: Auxiliary clock and control channel enables
// RQ16: Host disables lanes left unused
// RQ17: Registers reached over serial control port
// RQ18: Disabled lanes silent; fields hold their values
// RQ19: Format changes applied at frame boundary
`timescale 1ns/1ps
module sofc_format_config
  import sofc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic frame_active,
  input wire logic pix_valid,
  input wire sofc_lanes_t pix_data,
  output sofc_lanes_t lane_data,
  output logic [63:0] lane_en,
  output logic out_clk_en,
  output logic ctrl_chan_en,
  output logic in_clk_en,
  output logic [1:0] active_depth,
  output logic [15:0] sub_row_offset,
  output logic [7:0] ramp_range_code,
  output logic [1:0] ramp_multiplier,
  output logic [1:0] ramp_mult_low_clock
);

  // ==========
  // Types of the two state groups

  // Register-domain state
  typedef struct packed {
    logic [15:0] sub_row_offset;
    logic [4:0] chan_code;
    logic single_side;
    logic [11:0] sync_word;
    logic [15:0] lower_en_a;
    logic [15:0] lower_en_b;
    logic [15:0] upper_en_a;
    logic [15:0] upper_en_b;
    logic [2:0] aux_en;
    logic [1:0] ramp_mult_low;
    logic [7:0] ramp_range;
    logic [1:0] ramp_mult;
    logic [1:0] depth;
    logic pending;
  } sofc_core_t;

  // Link-domain state
  typedef struct packed {
    sofc_cfg_t staged;
    logic [4:0] chan_code;
    logic single_side;
    logic [1:0] depth;
    sofc_lanes_t lane_data;
    logic [63:0] lane_en;
    logic [2:0] aux_en;
  } sofc_link_t;

  localparam sofc_core_t SOFC_CORE_RST = '{
    sub_row_offset: SOFC_RST_SUB_ROW_OFFSET,
    chan_code: SOFC_RST_CHAN_CODE,
    single_side: SOFC_RST_SINGLE_SIDE,
    sync_word: SOFC_RST_SYNC_WORD,
    lower_en_a: SOFC_RST_CHAN_EN,
    lower_en_b: SOFC_RST_CHAN_EN,
    upper_en_a: SOFC_RST_CHAN_EN,
    upper_en_b: SOFC_RST_CHAN_EN,
    aux_en: SOFC_RST_AUX_EN,
    ramp_mult_low: SOFC_RST_RAMP_MULT_LOW,
    ramp_range: SOFC_RST_RAMP_RANGE,
    ramp_mult: SOFC_RST_RAMP_MULT,
    depth: SOFC_RST_DEPTH,
    pending: 1'b0
  };

  sofc_core_t core_r;
  sofc_core_t core_nxt;
  sofc_link_t link_r;
  sofc_link_t link_nxt;

  logic [6:0] reg_addr;
  logic [15:0] wr_data;
  logic wr_pulse;
  logic [15:0] rd_data;
  logic cfg_busy;
  logic cfg_load;
  sofc_cfg_t cfg_word;
  sofc_cfg_t link_cfg;
  logic link_cfg_new;
  logic [1:0] link_rst_r;
  logic link_rst;

  // ==========
  // Serial control port
  sofc_spi_slave u_spi (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .rd_data(rd_data),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_pulse(wr_pulse),
    .spi_miso(spi_miso)
  );

  // ==========
  // Read-back mux

  // Register read value for an address; unmapped reads as zero
  function automatic logic [15:0] sofc_read(input sofc_core_t c, input logic [6:0] a, input logic busy);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      SOFC_ADDR_SUB_ROW_OFFSET: v = c.sub_row_offset;
      SOFC_ADDR_OUT_FORMAT: v = {10'h000, c.single_side, c.chan_code};
      SOFC_ADDR_IDLE_SYNC_WORD: v = {4'h0, c.sync_word};
      SOFC_ADDR_LOWER_EN_A: v = c.lower_en_a;
      SOFC_ADDR_LOWER_EN_B: v = c.lower_en_b;
      SOFC_ADDR_UPPER_EN_A: v = c.upper_en_a;
      SOFC_ADDR_UPPER_EN_B: v = c.upper_en_b;
      SOFC_ADDR_AUX_EN: v = {13'h0000, c.aux_en};
      SOFC_ADDR_RAMP_MULT_LOW: v = {14'h0000, c.ramp_mult_low};
      SOFC_ADDR_RAMP: v = {6'h00, c.ramp_mult, c.ramp_range};
      SOFC_ADDR_PIXEL_DEPTH: v = {14'h0000, c.depth};
      SOFC_ADDR_STATUS: v = {15'h0000, busy | c.pending};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // Read word for the address the serial port holds
  always_comb begin
    rd_data = sofc_read(core_r, reg_addr, cfg_busy);
  end

  // ==========
  // Register file in the core domain
  always_comb begin
    core_nxt = core_r;
    // Start a crossing once the previous one is acknowledged
    if (cfg_load) begin
      core_nxt.pending = 1'b0;
    end
    // RQ18: fields change only on write
    if (wr_pulse) begin
      case (reg_addr)
        SOFC_ADDR_SUB_ROW_OFFSET: core_nxt.sub_row_offset = wr_data;
        SOFC_ADDR_OUT_FORMAT: begin
          // RQ1: channel-count field
          core_nxt.chan_code = wr_data[SOFC_CHAN_CODE_LSB +: 5];
          // RQ3: one-side flag
          core_nxt.single_side = wr_data[SOFC_SINGLE_SIDE_BIT];
          core_nxt.pending = 1'b1;
        end
        SOFC_ADDR_IDLE_SYNC_WORD: begin
          // RQ7: training word field
          core_nxt.sync_word = wr_data[11:0];
          core_nxt.pending = 1'b1;
        end
        SOFC_ADDR_LOWER_EN_A: begin
          // RQ13: bottom enables low half
          core_nxt.lower_en_a = wr_data;
          core_nxt.pending = 1'b1;
        end
        SOFC_ADDR_LOWER_EN_B: begin
          // RQ13: bottom enables high half
          core_nxt.lower_en_b = wr_data;
          core_nxt.pending = 1'b1;
        end
        SOFC_ADDR_UPPER_EN_A: begin
          // RQ14: top enables low half
          core_nxt.upper_en_a = wr_data;
          core_nxt.pending = 1'b1;
        end
        SOFC_ADDR_UPPER_EN_B: begin
          // RQ14: top enables high half
          core_nxt.upper_en_b = wr_data;
          core_nxt.pending = 1'b1;
        end
        SOFC_ADDR_AUX_EN: begin
          // RQ15: auxiliary channel enables
          core_nxt.aux_en = wr_data[2:0];
          core_nxt.pending = 1'b1;
        end
        SOFC_ADDR_RAMP_MULT_LOW: core_nxt.ramp_mult_low = wr_data[1:0];
        SOFC_ADDR_RAMP: begin
          core_nxt.ramp_range = wr_data[7:0];
          core_nxt.ramp_mult = wr_data[SOFC_RAMP_MULT_LSB +: 2];
        end
        SOFC_ADDR_PIXEL_DEPTH: begin
          // RQ8: pixel depth code
          core_nxt.depth = wr_data[1:0];
          core_nxt.pending = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // Core state register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_r <= SOFC_CORE_RST;
    end else begin
      core_r <= core_nxt;
    end
  end

  // Snapshot of the link-facing fields
  assign cfg_load = core_r.pending & ~cfg_busy;
  assign cfg_word = '{
    chan_code: core_r.chan_code,
    single_side: core_r.single_side,
    depth: core_r.depth,
    sync_word: core_r.sync_word,
    lower_en: {core_r.lower_en_b, core_r.lower_en_a},
    upper_en: {core_r.upper_en_b, core_r.upper_en_a},
    aux_en: core_r.aux_en
  };

  // ==========
  // Crossing into the link domain
  sofc_cdc u_cdc (
    .src_clk(core_clk),
    .src_rst(sys_rst),
    .src_load(cfg_load),
    .src_word(cfg_word),
    .src_busy(cfg_busy),
    .dst_clk(link_clk),
    .dst_rst(link_rst),
    .dst_word(link_cfg),
    .dst_new(link_cfg_new)
  );

  // Link reset: asserted at once, released on link_clk
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_rst_r <= 2'h3;
    end else begin
      link_rst_r <= {link_rst_r[0], 1'b0};
    end
  end

  assign link_rst = link_rst_r[1];

  // ==========
  // Lane drive in the link domain
  always_comb begin
    logic [5:0] used_cnt;
    logic [11:0] mask;
    logic [4:0] idx;
    logic is_top;
    logic in_use;
    logic en;
    used_cnt = 6'h00;
    mask = 12'h000;
    idx = 5'h00;
    is_top = 1'b0;
    in_use = 1'b0;
    en = 1'b0;
    link_nxt = link_r;
    // Newest crossed word is kept here; its format fields wait until the frame ends
    if (link_cfg_new) begin
      link_nxt.staged = link_cfg;
    end
    // RQ19: format held during a frame
    if (!frame_active) begin
      link_nxt.chan_code = link_nxt.staged.chan_code;
      link_nxt.single_side = link_nxt.staged.single_side;
      link_nxt.depth = link_nxt.staged.depth;
    end
    // RQ15: auxiliary enables follow at once
    link_nxt.aux_en = link_nxt.staged.aux_en;
    used_cnt = sofc_lane_count(link_r.chan_code);
    mask = sofc_depth_mask(link_r.depth);
    for (int i = 0; i < SOFC_NUM_LANES; i++) begin
      // RQ2: first half bottom, second half top
      is_top = (i >= SOFC_LANES_PER_SIDE);
      idx = 5'(i);
      // RQ1: only the first lanes of each side carry pixels
      // RQ3: top side unread in one-side mode
      in_use = ({1'b0, idx} < used_cnt) && !(is_top && link_r.single_side);
      // RQ13: bottom enable bit
      // RQ14: top enable bit
      en = is_top ? link_nxt.staged.upper_en[idx] : link_nxt.staged.lower_en[idx];
      link_nxt.lane_en[i] = en;
      if (!en) begin
        // RQ18: disabled lane silent
        link_nxt.lane_data[i] = 12'h000;
      end else if (frame_active && pix_valid && in_use) begin
        // RQ8: pixel cut to depth
        link_nxt.lane_data[i] = pix_data[i] & mask;
      end else begin
        // RQ6: training word when idle
        link_nxt.lane_data[i] = link_nxt.staged.sync_word;
      end
    end
  end

  // Link state register
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      link_r <= '{staged: SOFC_RST_CFG, depth: SOFC_RST_DEPTH, lane_en: '1, aux_en: SOFC_RST_AUX_EN, default: '0};
    end else begin
      link_r <= link_nxt;
    end
  end

  // ==========
  // Outputs
  assign lane_data = link_r.lane_data;
  assign lane_en = link_r.lane_en;
  assign out_clk_en = link_r.aux_en[0];
  assign ctrl_chan_en = link_r.aux_en[1];
  assign in_clk_en = link_r.aux_en[2];
  assign active_depth = link_r.depth;
  assign sub_row_offset = core_r.sub_row_offset;
  assign ramp_range_code = core_r.ramp_range;
  assign ramp_multiplier = core_r.ramp_mult;
  assign ramp_mult_low_clock = core_r.ramp_mult_low;

endmodule

//--- sofc_pkg.sv
// Shared constants, types and helpers for the sensor output format block.
// Assumes a serial control port addressing 7-bit registers of 16 data bits.
package sofc_pkg;

  // ==========
  // Sizes
  localparam int SOFC_LANES_PER_SIDE = 32;
  localparam int SOFC_NUM_LANES = 64;
  localparam int SOFC_PIX_W = 12;
  localparam int SOFC_ADDR_W = 7;
  localparam int SOFC_DATA_W = 16;
  localparam logic [4:0] SOFC_SPI_LAST_HDR = 5'h07;
  localparam logic [4:0] SOFC_SPI_FIRST_RD = 5'h09;
  localparam logic [4:0] SOFC_SPI_LAST_BIT = 5'h17;
  localparam logic [4:0] SOFC_SPI_DONE = 5'h18;

  // ==========
  // Register addresses
  localparam logic [6:0] SOFC_ADDR_SUB_ROW_OFFSET = 7'h42;
  localparam logic [6:0] SOFC_ADDR_OUT_FORMAT = 7'h51;
  localparam logic [6:0] SOFC_ADDR_IDLE_SYNC_WORD = 7'h59;
  localparam logic [6:0] SOFC_ADDR_LOWER_EN_A = 7'h5a;
  localparam logic [6:0] SOFC_ADDR_LOWER_EN_B = 7'h5b;
  localparam logic [6:0] SOFC_ADDR_UPPER_EN_A = 7'h5c;
  localparam logic [6:0] SOFC_ADDR_UPPER_EN_B = 7'h5d;
  localparam logic [6:0] SOFC_ADDR_AUX_EN = 7'h5e;
  localparam logic [6:0] SOFC_ADDR_RAMP_MULT_LOW = 7'h64;
  localparam logic [6:0] SOFC_ADDR_RAMP = 7'h74;
  localparam logic [6:0] SOFC_ADDR_PIXEL_DEPTH = 7'h76;
  localparam logic [6:0] SOFC_ADDR_STATUS = 7'h7e;

  // ==========
  // Field positions
  localparam int SOFC_CHAN_CODE_LSB = 0;
  localparam int SOFC_SINGLE_SIDE_BIT = 5;
  localparam int SOFC_RAMP_MULT_LSB = 8;
  localparam int SOFC_STATUS_BUSY_BIT = 0;

  // ==========
  // Reset values
  localparam logic [15:0] SOFC_RST_SUB_ROW_OFFSET = 16'h0000;
  localparam logic [4:0] SOFC_RST_CHAN_CODE = 5'h00;
  localparam logic SOFC_RST_SINGLE_SIDE = 1'b0;
  localparam logic [11:0] SOFC_RST_SYNC_WORD = 12'h055;
  localparam logic [15:0] SOFC_RST_CHAN_EN = 16'hffff;
  localparam logic [2:0] SOFC_RST_AUX_EN = 3'h7;
  localparam logic [1:0] SOFC_RST_RAMP_MULT_LOW = 2'h0;
  localparam logic [7:0] SOFC_RST_RAMP_RANGE = 8'h7f;
  localparam logic [1:0] SOFC_RST_RAMP_MULT = 2'h1;
  localparam logic [1:0] SOFC_RST_DEPTH = 2'h1;

  // ==========
  // Types
  typedef enum logic [1:0] {
    SOFC_DEPTH_12 = 2'b00,
    SOFC_DEPTH_10 = 2'b01,
    SOFC_DEPTH_8 = 2'b10
  } sofc_depth_t;

  typedef logic [SOFC_NUM_LANES-1:0][SOFC_PIX_W-1:0] sofc_lanes_t;

  // Configuration carried from the register domain to the link domain
  typedef struct packed {
    logic [4:0] chan_code;
    logic single_side;
    logic [1:0] depth;
    logic [11:0] sync_word;
    logic [31:0] lower_en;
    logic [31:0] upper_en;
    logic [2:0] aux_en;
  } sofc_cfg_t;

  localparam sofc_cfg_t SOFC_RST_CFG = '{
    chan_code: SOFC_RST_CHAN_CODE,
    single_side: SOFC_RST_SINGLE_SIDE,
    depth: SOFC_RST_DEPTH,
    sync_word: SOFC_RST_SYNC_WORD,
    lower_en: {SOFC_RST_CHAN_EN, SOFC_RST_CHAN_EN},
    upper_en: {SOFC_RST_CHAN_EN, SOFC_RST_CHAN_EN},
    aux_en: SOFC_RST_AUX_EN
  };

  // ==========
  // Helpers
  // Lanes used per side for a channel-count code; unlisted codes act as 32
  function automatic logic [5:0] sofc_lane_count(input logic [4:0] code);
    case (code)
      5'h00: sofc_lane_count = 6'h20;
      5'h01: sofc_lane_count = 6'h10;
      5'h03: sofc_lane_count = 6'h08;
      5'h07: sofc_lane_count = 6'h04;
      5'h0f: sofc_lane_count = 6'h02;
      5'h1f: sofc_lane_count = 6'h01;
      default: sofc_lane_count = 6'h20;
    endcase
  endfunction

  // Pixel bits kept for a depth code; unlisted code acts as 12 bits
  function automatic logic [11:0] sofc_depth_mask(input logic [1:0] depth);
    case (depth)
      SOFC_DEPTH_12: sofc_depth_mask = 12'hfff;
      SOFC_DEPTH_10: sofc_depth_mask = 12'h3ff;
      SOFC_DEPTH_8: sofc_depth_mask = 12'h0ff;
      default: sofc_depth_mask = 12'hfff;
    endcase
  endfunction

endpackage

//--- sofc_spi_slave.sv
// Serial control port slave: write flag, 7 address bits, 16 data bits, MSB first.
// Assumes pins are asynchronous and the serial clock is at most one eighth of core_clk.
`timescale 1ns/1ps
module sofc_spi_slave
  import sofc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic [15:0] rd_data,
  output logic [6:0] reg_addr,
  output logic [15:0] wr_data,
  output logic wr_pulse,
  output logic spi_miso
);

  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] mosi_s;
    logic sclk_d;
    logic [4:0] cnt;
    logic is_write;
    logic load_rd;
    logic [6:0] addr;
    logic [15:0] wdata;
    logic [15:0] rd_shift;
    logic wr_pulse;
    logic miso;
  } sofc_spi_state_t;

  sofc_spi_state_t st_r;
  sofc_spi_state_t st_nxt;

  // ==========
  // Frame decode
  always_comb begin
    logic rise;
    logic fall;
    logic bit_in;
    rise = 1'b0;
    fall = 1'b0;
    bit_in = 1'b0;
    st_nxt = st_r;
    // Two-stage pin synchronisers, stage 0 feeds only stage 1
    st_nxt.sclk_s = {st_r.sclk_s[0], spi_sclk};
    st_nxt.cs_s = {st_r.cs_s[0], spi_cs_n};
    st_nxt.mosi_s = {st_r.mosi_s[0], spi_mosi};
    st_nxt.sclk_d = st_r.sclk_s[1];
    rise = st_r.sclk_s[1] & ~st_r.sclk_d;
    fall = ~st_r.sclk_s[1] & st_r.sclk_d;
    bit_in = st_r.mosi_s[1];
    st_nxt.wr_pulse = 1'b0;
    st_nxt.load_rd = 1'b0;
    // RQ17: host register access
    if (st_r.cs_s[1]) begin
      st_nxt.cnt = 5'h00;
    end else begin
      // Read word is fetched once the address is complete
      if (st_r.load_rd) begin
        st_nxt.rd_shift = rd_data;
        st_nxt.miso = rd_data[15];
      end
      if (rise && st_r.cnt != SOFC_SPI_DONE) begin
        st_nxt.cnt = st_r.cnt + 5'h01;
        if (st_r.cnt == 5'h00) begin
          st_nxt.is_write = bit_in;
        end else if (st_r.cnt <= SOFC_SPI_LAST_HDR) begin
          st_nxt.addr = {st_r.addr[5:0], bit_in};
          st_nxt.load_rd = (st_r.cnt == SOFC_SPI_LAST_HDR);
        end else begin
          st_nxt.wdata = {st_r.wdata[14:0], bit_in};
          st_nxt.wr_pulse = st_r.is_write && (st_r.cnt == SOFC_SPI_LAST_BIT);
        end
      end
      // Next read bit is shifted out on each falling edge of the data phase except the last
      if (fall && st_r.cnt >= SOFC_SPI_FIRST_RD && st_r.cnt != SOFC_SPI_DONE) begin
        st_nxt.rd_shift = {st_r.rd_shift[14:0], 1'b0};
        st_nxt.miso = st_r.rd_shift[14];
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{cs_s: 2'h3, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_addr = st_r.addr;
  assign wr_data = st_r.wdata;
  assign wr_pulse = st_r.wr_pulse;
  assign spi_miso = st_r.miso;

endmodule

//--- sofc_cdc.sv
// Toggle handshake carrying one configuration word from core_clk to link_clk.
// Assumes the source loads only while not busy; the held word is stable until acknowledged.
`timescale 1ns/1ps
module sofc_cdc
  import sofc_pkg::*;
(
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic src_load,
  input wire sofc_cfg_t src_word,
  output logic src_busy,
  input wire logic dst_clk,
  input wire logic dst_rst,
  output sofc_cfg_t dst_word,
  output logic dst_new
);

  typedef struct packed {
    sofc_cfg_t hold;
    logic req;
    logic [1:0] ack_s;
  } sofc_cdc_src_t;

  typedef struct packed {
    sofc_cfg_t word;
    logic [1:0] req_s;
    logic req_d;
    logic new_pulse;
  } sofc_cdc_dst_t;

  sofc_cdc_src_t src_r;
  sofc_cdc_src_t src_nxt;
  sofc_cdc_dst_t dst_r;
  sofc_cdc_dst_t dst_nxt;

  // ==========
  // Source side: capture word and flip request
  always_comb begin
    src_nxt = src_r;
    src_nxt.ack_s = {src_r.ack_s[0], dst_r.req_d};
    if (src_load && (src_r.req == src_r.ack_s[1])) begin
      src_nxt.hold = src_word;
      src_nxt.req = ~src_r.req;
    end
  end

  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      src_r <= '{hold: SOFC_RST_CFG, default: '0};
    end else begin
      src_r <= src_nxt;
    end
  end

  assign src_busy = src_r.req ^ src_r.ack_s[1];

  // ==========
  // Destination side: take held word on request edge
  always_comb begin
    dst_nxt = dst_r;
    dst_nxt.req_s = {dst_r.req_s[0], src_r.req};
    dst_nxt.req_d = dst_r.req_s[1];
    dst_nxt.new_pulse = dst_r.req_s[1] ^ dst_r.req_d;
    if (dst_r.req_s[1] ^ dst_r.req_d) begin
      dst_nxt.word = src_r.hold;
    end
  end

  always_ff @(posedge dst_clk or posedge dst_rst) begin
    if (dst_rst) begin
      dst_r <= '{word: SOFC_RST_CFG, default: '0};
    end else begin
      dst_r <= dst_nxt;
    end
  end

  assign dst_word = dst_r.word;
  assign dst_new = dst_r.new_pulse;

endmodule

//--- sofc_props.sv
// Checker on the output format block ports.
// Assumes it is bound into sofc_format_config.
`timescale 1ns/1ps
module sofc_props
  import sofc_pkg::*;
(
  input logic core_clk,
  input logic sys_rst,
  input logic link_clk,
  input logic spi_cs_n,
  input logic spi_miso,
  input logic frame_active,
  input logic pix_valid,
  input sofc_lanes_t pix_data,
  input sofc_lanes_t lane_data,
  input logic [63:0] lane_en,
  input logic [1:0] active_depth,
  input logic [15:0] sub_row_offset,
  input logic [7:0] ramp_range_code,
  input logic [1:0] ramp_multiplier,
  input logic [1:0] ramp_mult_low_clock
);
  // ==========
  // Properties
  // Bits kept for the applied depth
  wire logic [11:0] msk = (active_depth == 2'h2) ? 12'h0ff : (active_depth == 2'h1) ? 12'h3ff : 12'hfff;
  // Serial port idle long enough
  sequence cs_idle;
    spi_cs_n [*8];
  endsequence
  a_fields_hold:
    assert property (@(posedge core_clk) disable iff (sys_rst) cs_idle |-> $stable({sub_row_offset, ramp_range_code}))
      else $error("field moved");
  a_mult_hold:
    assert property (@(posedge core_clk) disable iff (sys_rst) cs_idle |-> $stable({ramp_multiplier, ramp_mult_low_clock}))
      else $error("mult moved");
  a_miso_hold:
    assert property (@(posedge core_clk) disable iff (sys_rst) spi_cs_n [*6] |-> $stable(spi_miso))
      else $error("miso moved");
  a_idle_sync:
    assert property (@(posedge link_clk) disable iff (sys_rst) !$past(frame_active) && lane_en[0]
      && lane_en[63] && $past(lane_en[0]) && $past(lane_en[63]) |-> lane_data[0] == lane_data[63])
      else $error("idle lanes differ");
  a_lane0_zero:
    assert property (@(posedge link_clk) disable iff (sys_rst) !lane_en[0] && !$past(lane_en[0])
      |-> lane_data[0] == 12'h000) else $error("lane 0 not silent");
  a_lane63_zero:
    assert property (@(posedge link_clk) disable iff (sys_rst) !lane_en[63] && !$past(lane_en[63])
      |-> lane_data[63] == 12'h000) else $error("lane 63 not silent");
  a_depth_mask:
    assert property (@(posedge link_clk) disable iff (sys_rst) $past(frame_active && pix_valid)
      && lane_en[0] && $past(lane_en[0]) |-> lane_data[0] == ($past(pix_data[0]) & msk))
      else $error("lane 0 not masked");
  a_depth_frame:
    assert property (@(posedge link_clk) disable iff (sys_rst) $past(frame_active) && $past(frame_active, 2)
      |-> $stable(active_depth)) else $error("depth moved in frame");
endmodule

bind sofc_format_config sofc_props u_props (.core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk),
  .spi_cs_n(spi_cs_n), .spi_miso(spi_miso), .frame_active(frame_active), .pix_valid(pix_valid),
  .pix_data(pix_data), .lane_data(lane_data), .lane_en(lane_en), .active_depth(active_depth),
  .sub_row_offset(sub_row_offset), .ramp_range_code(ramp_range_code), .ramp_multiplier(ramp_multiplier),
  .ramp_mult_low_clock(ramp_mult_low_clock));

//--- sofc_rx_model.sv
// Receiver model: captures every lane word on the link clock.
// Assumes lane_data comes from the block under test.
`timescale 1ns/1ps
module sofc_rx_model
  import sofc_pkg::*;
(
  input wire logic link_clk,
  input wire sofc_lanes_t lane_data,
  output sofc_lanes_t cap_r
);
  // ==========
  // Capture each link cycle
  always_ff @(posedge link_clk) begin
    cap_r <= lane_data;
  end
endmodule

//--- test_sofc_format_config.sv
// Bench: serial register access and lane checks.
// Assumes the receiver model and checker compile first.
`timescale 1ns/1ps
module test_sofc_format_config
  import sofc_pkg::*;
;
  // ==========
  // Signals
  logic core_clk = 0, link_clk = 0, sys_rst = 1, spi_sclk = 0, spi_cs_n = 1, spi_mosi = 0;
  logic frame_active = 0, pix_valid = 0, spi_miso, out_clk_en, ctrl_chan_en, in_clk_en;
  sofc_lanes_t pix_data = '0, lane_data, cap;
  logic [63:0] lane_en;
  logic [1:0] active_depth, ramp_multiplier, ramp_mult_low_clock;
  logic [15:0] sub_row_offset;
  logic [7:0] ramp_range_code;
  logic [15:0] rt [3] = '{16'h03e6, 16'h01a5, 16'h00cd};
  int n_errors = 0, samples_checked = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  // no subsampling, link clock never changed
  initial begin
    #3;
    forever #15 link_clk = ~link_clk;
  end
  sofc_format_config dut (.core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .frame_active(frame_active),
    .pix_valid(pix_valid), .pix_data(pix_data), .lane_data(lane_data), .lane_en(lane_en),
    .out_clk_en(out_clk_en), .ctrl_chan_en(ctrl_chan_en), .in_clk_en(in_clk_en), .active_depth(active_depth),
    .sub_row_offset(sub_row_offset), .ramp_range_code(ramp_range_code), .ramp_multiplier(ramp_multiplier),
    .ramp_mult_low_clock(ramp_mult_low_clock));
  sofc_rx_model rx (.link_clk(link_clk), .lane_data(lane_data), .cap_r(cap));
  // ==========
  // Tasks
  task finish_test();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  // One serial frame, sampling miso at each of the 16 data-phase rises
  task spi(input logic [23:0] w, output logic [15:0] r);
    @(posedge core_clk);
    spi_cs_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_mosi <= w[i];
      repeat (5) @(posedge core_clk);
      spi_sclk <= 1'b1;
      if (i < 16) r[i] = spi_miso;
      repeat (5) @(posedge core_clk);
      spi_sclk <= 1'b0;
    end
    repeat (8) @(posedge core_clk);
    spi_cs_n <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask
  task wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] r;
    spi({1'b1, a, d}, r);
  endtask
  task rd(input logic [6:0] a, input logic [15:0] want);
    logic [15:0] r;
    spi({1'b0, a, 16'h0000}, r);
    chk(r, want);
  endtask
  // Write, then poll until the crossing is done
  task cfg(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] s;
    wr(a, d);
    s = 16'h0001;
    for (int k = 0; k < 20 && s[0] !== 1'b0; k++) spi({1'b0, SOFC_ADDR_STATUS, 16'h0000}, s);
    chk(s, 16'h0000);
    repeat (6) @(posedge link_clk);
  endtask
  task frame(input logic act, input logic [11:0] px);
    @(posedge link_clk);
    frame_active <= act;
    pix_valid <= act;
    pix_data <= {64{px}};
    repeat (3) @(posedge link_clk);
    #1;
  endtask
  function automatic logic [15:0] exp_lane(input int l, input int n, input logic one, input logic [1:0] dp,
    input logic [11:0] px, input logic [11:0] tw);
    logic [11:0] m;
    m = (dp == 2'h2) ? 12'h0ff : (dp == 2'h1) ? 12'h3ff : 12'hfff;
    if ((l % 32) < n && !(one && l >= 32)) return {4'h0, px & m};
    return {4'h0, tw};
  endfunction
  // ==========
  // Main sequence and hang limit
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    logic [15:0] d;
    logic [11:0] tw, px;
    int n;
    int ln [4];
    void'($urandom(13815));
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(SOFC_ADDR_OUT_FORMAT, 16'h0000);
    rd(SOFC_ADDR_IDLE_SYNC_WORD, 16'h0055);
    rd(SOFC_ADDR_LOWER_EN_B, 16'hffff);
    rd(SOFC_ADDR_UPPER_EN_A, 16'hffff);
    rd(SOFC_ADDR_AUX_EN, 16'h0007);
    rd(SOFC_ADDR_RAMP, 16'h017f);
    rd(SOFC_ADDR_PIXEL_DEPTH, 16'h0001);
    chk(sub_row_offset, 16'h0000);
    $display("reset values done");
    d = 16'($urandom);
    wr(SOFC_ADDR_RAMP_MULT_LOW, d);
    rd(SOFC_ADDR_RAMP_MULT_LOW, {14'h0000, d[1:0]});
    wr(7'h10, d);
    rd(7'h10, 16'h0000);
    tw = 12'($urandom);
    cfg(SOFC_ADDR_IDLE_SYNC_WORD, {4'h0, tw});
    frame(1'b0, 12'h000);
    chk(cap[40], {4'h0, tw});
    $display("register access done");
    for (int k = 0; k < 3; k++) begin
      wr(SOFC_ADDR_RAMP, rt[k]);
      chk({ramp_multiplier, 6'h00, ramp_range_code}, {rt[k][9:8], 6'h00, rt[k][7:0]});
      cfg(SOFC_ADDR_PIXEL_DEPTH, 16'(k));
      px = 12'($urandom);
      frame(1'b1, px);
      chk(cap[3], exp_lane(3, 32, 1'b0, 2'(k), px, tw));
      chk({14'h0000, active_depth}, 16'(k));
      frame(1'b0, px);
    end
    $display("depth modes done");
    for (int k = 0; k < 6; k++) begin
      if (k[0]) wr(SOFC_ADDR_SUB_ROW_OFFSET, 16'hffff);
      cfg(SOFC_ADDR_OUT_FORMAT, {10'h000, k[0], 5'((1 << k) - 1)});
      n = 32 >> k;
      ln = '{n - 1, n, 32, 31 + n};
      px = 12'($urandom);
      frame(1'b1, px);
      for (int j = 0; j < 4; j++) chk(cap[ln[j]], exp_lane(ln[j], n, k[0], 2'h2, px, tw));
      frame(1'b0, px);
    end
    $display("channel modes done");
    cfg(SOFC_ADDR_LOWER_EN_A, 16'hfffe);
    cfg(SOFC_ADDR_UPPER_EN_B, 16'h7fff);
    cfg(SOFC_ADDR_AUX_EN, 16'h0005);
    frame(1'b1, 12'($urandom));
    chk(cap[0], 16'h0000);
    chk({12'h000, lane_en[63], lane_en[62], lane_en[1], lane_en[0]}, 16'h0006);
    chk({13'h0000, in_clk_en, ctrl_chan_en, out_clk_en}, 16'h0005);
    chk(sub_row_offset, 16'hffff);
    frame(1'b0, 12'h000);
    $display("channel enables done");
    finish_test();
  end
endmodule
